// *** rtl/lbb_bridge.sv ***
`timescale 1ns/1ps
module lbb_bridge #(
  parameter int LCLK_DIV = lbb_pkg::LCLK_DIV_DEF
) (
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire lbb_pkg::lbb_pci_req_t pci_req,
  output lbb_pkg::lbb_pci_rsp_t     pci_rsp,
  input  wire logic [2:0]           periph_pin_config,
  input  wire lbb_pkg::lbb_lcfg_t   local_bus_config,
  input  wire logic                 host_strap_a,
  output logic                      host_mode,
  output logic [31:0]               host_addr,
  output logic                      addr_latch_strobe,
  output logic                      local_read_strobe_n,
  output logic                      local_write_strobe_n,
  output logic                      strobe_oe,
  input  wire logic                 local_ready_n,
  output logic                      lbus_req,
  input  wire logic                 lbus_gnt,
  input  wire logic                 ext_hold_req,
  output logic                      ext_hold_ack,
  output logic                      lbi_busy,
  output logic                      rd_data_held,
  input  wire logic [15:0]          gp_io_port_o,
  input  wire logic [15:0]          gp_io_port_oe,
  output logic [15:0]               gp_io_port_i,
  input  wire logic [7:0]           sync_serial_port_o,
  input  wire logic [7:0]           sync_serial_port_oe,
  output logic [7:0]                sync_serial_port_i,
  input  wire logic [31:0]          pin_i,
  output logic [31:0]               pin_o,
  output logic [31:0]               pin_oe
);
  import lbb_pkg::*;

  localparam logic [7:0] DIV_TOP = 8'(LCLK_DIV - 1);

  //////////////////////////////////////////////////////////////////////////
  // Reset release, strap capture, configuration, local clock enable

  logic        rst_s1_q;
  logic        rst_n;
  logic        strap_done_q;
  logic        strap_q;
  logic [2:0]  pcfg_q;
  lbb_lcfg_t   lcfg_q;
  logic [7:0]  div_q;
  logic [7:0]  div_d;
  logic        lclk_en;
  logic        rdy_s1_q;
  logic        rdy_s2_q;
  logic [31:0] host_addr_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  assign lclk_en = (div_q == DIV_TOP);
  assign div_d   = lclk_en ? 8'h00 : div_q + 8'h01;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_q <= 1'b0;
      strap_q      <= 1'b0;
      pcfg_q       <= PCFG_HOST_STRAP_A_ALL;
      lcfg_q       <= LCFG_RST;
      div_q        <= 8'h00;
      rdy_s1_q     <= 1'b1;
      rdy_s2_q     <= 1'b1;
      host_addr_q  <= '0;
    end else begin
      strap_done_q <= 1'b1;
      if (!strap_done_q) begin
        strap_q <= host_strap_a;
      end
      pcfg_q      <= periph_pin_config;
      lcfg_q      <= local_bus_config;
      div_q       <= div_d;
      rdy_s1_q    <= local_ready_n;
      rdy_s2_q    <= rdy_s1_q;
      host_addr_q <= strap_q ? pin_i : '0;
    end
  end

  assign host_mode = strap_q;
  assign host_addr = host_addr_q;

  logic lbi_en;
  logic mux_mode;

  assign mux_mode = (pcfg_q == PCFG_SSC_MUX) || (pcfg_q == PCFG_GP_MUX);
  assign lbi_en   = !strap_q && (mux_mode || pcfg_q == PCFG_HOST_STRAP_A_ALL ||
                                 pcfg_q == PCFG_GP_HI);

  //////////////////////////////////////////////////////////////////////////
  // Transfer control and local bus sequencing

  lbb_state_t  state_q;
  lbb_state_t  state_d;
  logic        wr_op_q;
  logic        wr_op_d;
  logic        held_q;
  logic        held_d;
  logic [15:0] base_q;
  logic [15:0] base_d;
  logic [15:0] held_addr_q;
  logic [15:0] held_addr_d;
  logic [31:0] wbuf_q;
  logic [31:0] wbuf_d;
  logic [31:0] rbuf_q;
  logic [31:0] rbuf_d;
  logic [1:0]  beat_q;
  logic [1:0]  beat_d;
  logic [4:0]  cnt_q;
  logic [4:0]  cnt_d;
  logic [15:0] la_q;
  logic [15:0] la_d;
  logic [15:0] ld_o_q;
  logic [15:0] ld_o_d;
  logic [1:0]  ld_oe_q;
  logic [1:0]  ld_oe_d;
  logic        ale_q;
  logic        ale_d;
  logic        rd_n_q;
  logic        rd_n_d;
  logic        wr_n_q;
  logic        wr_n_d;

  logic [15:0] cur_addr;
  logic [15:0] wr_lane;
  logic [15:0] ld_i;
  logic        last_beat;
  logic        drive;

  assign cur_addr  = lcfg_q.width16 ? base_q + {13'h0, beat_q, 1'b0}
                                    : base_q + {14'h0, beat_q};
  assign wr_lane   = lcfg_q.width16 ? wbuf_q[beat_q[0]*16 +: 16]
                                    : {8'h00, wbuf_q[beat_q*8 +: 8]};
  assign last_beat = lcfg_q.width16 ? (beat_q == BEAT_LAST16)
                                    : (beat_q == BEAT_LAST8);

  always_comb begin
    state_d     = state_q;
    wr_op_d     = wr_op_q;
    held_d      = held_q;
    base_d      = base_q;
    held_addr_d = held_addr_q;
    wbuf_d      = wbuf_q;
    rbuf_d      = rbuf_q;
    beat_d      = beat_q;
    cnt_d       = cnt_q;
    la_d        = la_q;
    ld_o_d      = ld_o_q;
    ld_oe_d     = ld_oe_q;
    ale_d       = ale_q;
    rd_n_d      = rd_n_q;
    wr_n_d      = wr_n_q;
    pci_rsp       = '0;
    pci_rsp.rdata = rbuf_q;

    // Host side: one DWORD per transaction
    if (pci_req.valid) begin
      if (!lbi_en) begin
        pci_rsp.ack = 1'b1;
      end else if (pci_req.write) begin
        if (state_q == ST_IDLE) begin
          pci_rsp.ack = 1'b1;
          wbuf_d      = pci_req.wdata;
          base_d      = {pci_req.addr[15:2], 2'b00};
          wr_op_d     = 1'b1;
          beat_d      = '0;
          state_d     = ST_ARB;
        end else begin
          pci_rsp.retry = 1'b1;
        end
      end else if (held_q && pci_req.addr == held_addr_q) begin
        pci_rsp.ack = 1'b1;
        held_d      = 1'b0;
      end else begin
        pci_rsp.retry = 1'b1;
        if (state_q == ST_IDLE) begin
          base_d  = {pci_req.addr[15:2], 2'b00};
          wr_op_d = 1'b0;
          held_d  = 1'b0;
          beat_d  = '0;
          state_d = ST_ARB;
        end
      end
      pci_rsp.disc = pci_rsp.ack && pci_req.burst;
    end

    if (lclk_en) begin
      unique case (state_q)
        ST_IDLE: begin
          if (ext_hold_req && !lcfg_q.arb_slave && pci_rsp.ack == 1'b0
              && state_d == ST_IDLE) begin
            state_d = ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (!ext_hold_req) begin
            state_d = ST_IDLE;
          end
        end
        ST_ARB: begin
          if (!lcfg_q.arb_slave || lbus_gnt) begin
            state_d = mux_mode ? ST_ALE : ST_STRB;
          end
        end
        ST_ALE: begin
          state_d = ST_ADR;
        end
        ST_ADR: begin
          state_d = ST_STRB;
        end
        ST_STRB: begin
          if (cnt_q != '0) begin
            cnt_d = cnt_q - 5'h01;
          end else if (lcfg_q.ready_wait_enable) begin
            cnt_d   = {2'b00, lcfg_q.rdy_ws};
            state_d = ST_RDYW;
          end else begin
            state_d = ST_END;
          end
        end
        ST_RDYW: begin
          if (cnt_q != '0) begin
            cnt_d = cnt_q - 5'h01;
          end else if (!rdy_s2_q) begin
            state_d = ST_END;
          end
        end
        ST_END: begin
          beat_d = beat_q + 2'h1;
          if (last_beat) begin
            state_d = ST_IDLE;
            if (!wr_op_q) begin
              held_d      = 1'b1;
              held_addr_d = base_q;
            end
          end else begin
            state_d = mux_mode ? ST_ALE : ST_STRB;
          end
        end
        default: state_d = ST_IDLE;
      endcase

      // Pin values for the state being entered
      if (state_d == ST_ALE && state_q != ST_ALE) begin
        ale_d   = 1'b1;
        ld_o_d  = cur_addr_next(state_q == ST_END);
        ld_oe_d = LANES_ALL;
      end
      if (state_d == ST_ADR) begin
        ale_d = 1'b0;
      end
      if (state_d == ST_STRB && state_q != ST_STRB) begin
        cnt_d = (STRB_MIN - 5'h01)
              + {1'b0, CYCLE_WAIT_COUNT_MAX - lcfg_q.cycle_wait_count};
        if (mux_mode) begin
          // Address leaves the shared pins on the edge the strobe falls; 8-bit mode keeps its upper byte on LANE_HI
          ld_oe_d = lcfg_q.width16 ? 2'b00 : LANE_HI;
          ld_o_d  = lcfg_q.width16 ? 16'h0000
                                   : {ld_o_q[15:8], 8'h00};
        end else begin
          la_d    = cur_addr_next(state_q == ST_END);
          ld_oe_d = 2'b00;
        end
        if (wr_op_q) begin
          ld_o_d  = lcfg_q.width16 ? 16'h0000 : {ld_o_d[15:8], 8'h00};
          ld_o_d  = ld_o_d | wr_lane_next(state_q == ST_END);
          ld_oe_d = lcfg_q.width16 ? LANES_ALL
                                   : (ld_oe_d | LANE_LO);
          wr_n_d  = 1'b0;
        end else begin
          rd_n_d = 1'b0;
        end
      end
      if (state_d == ST_END && state_q != ST_END) begin
        rd_n_d = 1'b1;
        wr_n_d = 1'b1;
        if (!wr_op_q) begin
          if (lcfg_q.width16) begin
            rbuf_d[beat_q[0]*16 +: 16] = ld_i;
          end else begin
            rbuf_d[beat_q*8 +: 8] = ld_i[7:0];
          end
        end
      end
      if (state_d == ST_IDLE && state_q == ST_END && !wr_op_q) begin
        ld_oe_d = 2'b00;
      end
    end
  end

  // Address and data of the beat to be run: the next one when adv is set, else the current one
  function automatic logic [15:0] cur_addr_next(input logic adv);
    logic [1:0] b;
    b = adv ? beat_q + 2'h1 : beat_q;
    cur_addr_next = lcfg_q.width16 ? base_q + {13'h0, b, 1'b0}
                                   : base_q + {14'h0, b};
  endfunction

  function automatic logic [15:0] wr_lane_next(input logic adv);
    logic [1:0] b;
    b = adv ? beat_q + 2'h1 : beat_q;
    wr_lane_next = lcfg_q.width16 ? wbuf_q[b[0]*16 +: 16]
                                  : {8'h00, wbuf_q[b*8 +: 8]};
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= ST_IDLE;
      wr_op_q     <= 1'b0;
      held_q      <= 1'b0;
      base_q      <= '0;
      held_addr_q <= '0;
      wbuf_q      <= '0;
      rbuf_q      <= '0;
      beat_q      <= '0;
      cnt_q       <= '0;
      la_q        <= '0;
      ld_o_q      <= '0;
      ld_oe_q     <= 2'b00;
      ale_q       <= 1'b0;
      rd_n_q      <= 1'b1;
      wr_n_q      <= 1'b1;
    end else begin
      state_q     <= state_d;
      wr_op_q     <= wr_op_d;
      held_q      <= held_d;
      base_q      <= base_d;
      held_addr_q <= held_addr_d;
      wbuf_q      <= wbuf_d;
      rbuf_q      <= rbuf_d;
      beat_q      <= beat_d;
      cnt_q       <= cnt_d;
      la_q        <= la_d;
      ld_o_q      <= ld_o_d;
      ld_oe_q     <= ld_oe_d;
      ale_q       <= ale_d;
      rd_n_q      <= rd_n_d;
      wr_n_q      <= wr_n_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin drive and sharing

  // Bus released while held by another master or, as slave, when idle or waiting in ST_ARB for the grant
  assign drive = lbi_en && (state_q != ST_HOLD) &&
                 !(lcfg_q.arb_slave && (state_q == ST_IDLE ||
                                        state_q == ST_ARB));

  assign addr_latch_strobe    = ale_q;
  assign local_read_strobe_n  = rd_n_q;
  assign local_write_strobe_n = wr_n_q;
  assign strobe_oe            = drive;
  assign lbus_req     = lcfg_q.arb_slave && state_q != ST_IDLE &&
                        state_q != ST_HOLD;
  assign ext_hold_ack = (state_q == ST_HOLD);
  assign lbi_busy     = (state_q != ST_IDLE) && (state_q != ST_HOLD);
  assign rd_data_held = held_q;

  lbb_pin_mux u_pin_mux (
    .strap_q (strap_q),
    .pcfg    (pcfg_q),
    .la      (la_q),
    .la_oe   (drive),
    .ld_o    (ld_o_q),
    .ld_oe   (ld_oe_q & {2{drive}}),
    .gp_o    (gp_io_port_o),
    .gp_oe   (gp_io_port_oe),
    .ssc_o   (sync_serial_port_o),
    .ssc_oe  (sync_serial_port_oe),
    .pin_i   (pin_i),
    .pin_o   (pin_o),
    .pin_oe  (pin_oe),
    .ld_i    (ld_i),
    .gp_i    (gp_io_port_i),
    .ssc_i   (sync_serial_port_i)
  );

  // Unused view kept for readability of the beat arithmetic
  logic unused_ok;
  assign unused_ok = ^{cur_addr, wr_lane};

endmodule

// *** rtl/lbb_pkg.sv ***
package lbb_pkg;

  // Peripheral pin configuration codes; other codes are reserved
  localparam logic [2:0] PCFG_HOST_STRAP_A_ALL = 3'h0;
  localparam logic [2:0] PCFG_GP_HI     = 3'h2;
  localparam logic [2:0] PCFG_SSC_MUX   = 3'h3;
  localparam logic [2:0] PCFG_GP_MUX    = 3'h4;

  localparam logic [3:0] CYCLE_WAIT_COUNT_MAX   = 4'hf;
  localparam logic [3:0] CYCLE_WAIT_COUNT_RST   = 4'hf;
  localparam logic [2:0] RDY_WS_RST = 3'h0;
  // Shortest strobe, in local clocks
  localparam logic [4:0] STRB_MIN   = 5'h2;
  localparam logic [1:0] BEAT_LAST16 = 2'h1;
  localparam logic [1:0] BEAT_LAST8  = 2'h3;
  localparam logic [1:0] LANES_ALL   = 2'h3;
  localparam logic [1:0] LANE_LO     = 2'h1;
  localparam logic [1:0] LANE_HI     = 2'h2;
  // System clocks per local clock
  localparam int LCLK_DIV_DEF = 4;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        burst;
    logic [15:0] addr;
    logic [31:0] wdata;
  } lbb_pci_req_t;

  typedef struct packed {
    logic        ack;
    logic        retry;
    logic        disc;
    logic [31:0] rdata;
  } lbb_pci_rsp_t;

  typedef struct packed {
    logic       width16;
    logic [3:0] cycle_wait_count;
    logic       ready_wait_enable;
    logic [2:0] rdy_ws;
    logic       arb_slave;
  } lbb_lcfg_t;

  localparam lbb_lcfg_t LCFG_RST = '{width16: 1'b1,
                                     cycle_wait_count: CYCLE_WAIT_COUNT_RST,
                                     ready_wait_enable: 1'b0,
                                     rdy_ws: RDY_WS_RST,
                                     arb_slave: 1'b0};

  typedef enum logic [2:0] {
    ST_IDLE, ST_ARB, ST_ALE, ST_ADR, ST_STRB, ST_RDYW, ST_END, ST_HOLD
  } lbb_state_t;

endpackage

// *** rtl/lbb_pin_mux.sv ***
`timescale 1ns/1ps
module lbb_pin_mux (
  input  wire logic        strap_q,
  input  wire logic [2:0]  pcfg,
  input  wire logic [15:0] la,
  input  wire logic        la_oe,
  input  wire logic [15:0] ld_o,
  input  wire logic [1:0]  ld_oe,
  input  wire logic [15:0] gp_o,
  input  wire logic [15:0] gp_oe,
  input  wire logic [7:0]  ssc_o,
  input  wire logic [7:0]  ssc_oe,
  input  wire logic [31:0] pin_i,
  output logic      [31:0] pin_o,
  output logic      [31:0] pin_oe,
  output logic      [15:0] ld_i,
  output logic      [15:0] gp_i,
  output logic      [7:0]  ssc_i
);
  import lbb_pkg::*;

  // Pin groups: [31:16] data, [15:8] upper, [7:0] lower
  always_comb begin
    pin_o  = '0;
    pin_oe = '0;
    ld_i   = pin_i[31:16];
    gp_i   = pin_i[15:0];
    ssc_i  = pin_i[7:0];
    if (!strap_q) begin
      unique case (pcfg)
        PCFG_HOST_STRAP_A_ALL: begin
          pin_o  = {ld_o, la};
          pin_oe = {{8{ld_oe[1]}}, {8{ld_oe[0]}}, {16{la_oe}}};
        end
        PCFG_GP_HI: begin
          pin_o  = {ld_o, gp_o[15:8], la[7:0]};
          pin_oe = {{8{ld_oe[1]}}, {8{ld_oe[0]}}, gp_oe[15:8],
                    {8{la_oe}}};
        end
        PCFG_SSC_MUX: begin
          pin_o  = {ld_o, gp_o[15:8], ssc_o};
          pin_oe = {{8{ld_oe[1]}}, {8{ld_oe[0]}}, gp_oe[15:8], ssc_oe};
        end
        PCFG_GP_MUX: begin
          pin_o  = {ld_o, gp_o};
          pin_oe = {{8{ld_oe[1]}}, {8{ld_oe[0]}}, gp_oe};
        end
        default: begin
          // Reserved codes leave every shared pin floating
          pin_o  = '0;
          pin_oe = '0;
        end
      endcase
    end
  end

endmodule

// *** test/lbb_bridge_properties.sv ***
`timescale 1ns/1ps
module lbb_bridge_properties #(
  parameter int LCLK_DIV = 4
) (
  input wire logic                  clk,
  input wire logic                  arst_n,
  input wire lbb_pkg::lbb_pci_req_t pci_req,
  input wire lbb_pkg::lbb_pci_rsp_t pci_rsp,
  input wire lbb_pkg::lbb_lcfg_t    local_bus_config,
  input wire logic                  host_mode,
  input wire logic [31:0]           host_addr,
  input wire logic                  addr_latch_strobe,
  input wire logic                  local_read_strobe_n,
  input wire logic                  local_write_strobe_n,
  input wire logic                  strobe_oe,
  input wire logic                  ext_hold_ack,
  input wire logic                  lbi_busy,
  input wire logic                  rd_data_held,
  input wire logic [31:0]           pin_i,
  input wire logic [31:0]           pin_o,
  input wire logic [31:0]           pin_oe
);
  import lbb_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic       strb;
  logic [7:0] lo_d;
  logic [7:0] lo_q;
  logic [7:0] nom;
  logic [7:0] nom_rdy;
  // Clocks spent with a strobe low
  always_comb begin
    strb = !local_read_strobe_n || !local_write_strobe_n;
    lo_d = strb ? lo_q + 8'h1 : 8'h0;
    nom = 8'((17 - int'(local_bus_config.cycle_wait_count)) * LCLK_DIV);
    nom_rdy = nom + 8'(int'(local_bus_config.rdy_ws) * LCLK_DIV);
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lo_q <= 8'h0;
    end else begin
      lo_q <= lo_d;
    end
  end
  ////////////////////////////////////////////////////////////////////
  AST_STRAP_ADDR: assert property (host_mode && $past(host_mode)
    |-> host_addr == $past(pin_i)) else $error("host address wrong");
  AST_STRAP_QUIET: assert property (host_mode |-> pin_oe == 32'h0
    && strb == 1'b0) else $error("pins driven in strap mode");
  AST_RD_RETRY: assert property (pci_req.valid && !pci_req.write
    && !rd_data_held && !host_mode |-> pci_rsp.retry && !pci_rsp.ack)
    else $error("read not retried");
  AST_WR_POST: assert property (pci_req.valid && pci_req.write
    && !lbi_busy && !host_mode |-> pci_rsp.ack && !pci_rsp.retry
    ##1 lbi_busy) else $error("write not posted");
  AST_WR_RETRY: assert property (pci_req.valid && pci_req.write
    && lbi_busy && !host_mode |-> pci_rsp.retry && !pci_rsp.ack)
    else $error("write during post not retried");
  AST_BURST_DISC: assert property (pci_req.valid && pci_req.burst
    && pci_rsp.ack && !host_mode |-> pci_rsp.disc)
    else $error("burst not disconnected");
  AST_STRB_LEN: assert property ($fell(strb)
    && !local_bus_config.ready_wait_enable |-> lo_q == nom)
    else $error("strobe length wrong");
  AST_RDY_MIN: assert property ($fell(strb)
    && local_bus_config.ready_wait_enable |-> lo_q >= nom_rdy)
    else $error("ready strobe too short");
  AST_ALE_ADDR: assert property ($fell(addr_latch_strobe)
    |-> pin_oe[31:16] == 16'hffff && $stable(pin_o[31:16]))
    else $error("address not held at latch fall");
  AST_HOLD_FLOAT: assert property (ext_hold_ack
    |-> pin_oe[31:16] == 16'h0 && !strobe_oe)
    else $error("bus driven during hold");
  AST_STRB_EXCL: assert property (!(strb && addr_latch_strobe)
    && (local_read_strobe_n || local_write_strobe_n))
    else $error("strobes overlap");
  cover property (pci_req.valid && pci_rsp.disc);
  cover property ($fell(addr_latch_strobe));
  cover property (ext_hold_ack);
endmodule
bind lbb_bridge lbb_bridge_properties #(.LCLK_DIV(LCLK_DIV)) u_props (
  .clk(clk), .arst_n(arst_n), .pci_req(pci_req), .pci_rsp(pci_rsp),
  .local_bus_config(local_bus_config), .host_mode(host_mode),
  .host_addr(host_addr), .addr_latch_strobe(addr_latch_strobe),
  .local_read_strobe_n(local_read_strobe_n),
  .local_write_strobe_n(local_write_strobe_n), .strobe_oe(strobe_oe),
  .ext_hold_ack(ext_hold_ack), .lbi_busy(lbi_busy),
  .rd_data_held(rd_data_held), .pin_i(pin_i), .pin_o(pin_o),
  .pin_oe(pin_oe));

// *** test/lbb_lbus_periph.sv ***
`timescale 1ns/1ps
module lbb_lbus_periph (
  input  wire logic        clk,
  input  wire logic [2:0]  pcfg,
  input  wire logic        width16,
  input  wire logic        ale,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [31:0] pin_o,
  input  wire logic [15:0] bus_seen,
  input  wire logic [3:0]  rdy_dly,
  output logic      [15:0] data_drv,
  output logic             ready_n
);
  logic [7:0]  mem [int];
  logic [15:0] adr;
  logic [15:0] adr_q = 16'h0;
  logic [15:0] last_q = 16'h0;
  logic        ale_q = 1'b0;
  logic        wr_q = 1'b1;
  logic [4:0]  wcnt_q = 5'h0;
  initial ready_n = 1'b1;
  function automatic logic [7:0] rb(input logic [15:0] a);
    return mem.exists(a) ? mem[a] : 8'h00;
  endfunction
  function automatic logic [31:0] rd32(input logic [15:0] a);
    return {rb(a + 16'h3), rb(a + 16'h2), rb(a + 16'h1), rb(a)};
  endfunction
  ////////////////////////////////////////////////////////////////////
  always_comb begin
    case (pcfg)
      3'h0:    adr = pin_o[15:0];
      3'h2:    adr = {8'h00, pin_o[7:0]};
      default: adr = adr_q;
    endcase
    // Released lines show the inverse of their last level
    if (!rd_n) begin
      data_drv = width16 ? {rb(adr + 16'h1), rb(adr)}
                         : {~last_q[15:8], rb(adr)};
    end else begin
      data_drv = ~last_q;
    end
  end
  always @(posedge clk) begin
    last_q <= bus_seen;
    ale_q <= ale;
    wr_q <= wr_n;
    if (ale_q && !ale) adr_q <= pin_o[31:16];
    if (!wr_q && wr_n) begin
      mem[adr] = pin_o[23:16];
      if (width16) mem[adr + 16'h1] = pin_o[31:24];
    end
    wcnt_q <= (!rd_n || !wr_n) ? wcnt_q + 5'h1 : 5'h0;
    ready_n <= !((!rd_n || !wr_n) && wcnt_q >= 5'(rdy_dly));
  end
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import lbb_pkg::*;
  logic         clk = 1'b0;
  logic         arst_n = 1'b0;
  lbb_pci_req_t pci_req = '0;
  lbb_pci_rsp_t pci_rsp;
  lbb_pci_rsp_t rsp;
  logic [2:0]   periph_pin_config = PCFG_HOST_STRAP_A_ALL;
  lbb_lcfg_t    local_bus_config = LCFG_RST;
  logic         host_strap_a = 1'b0;
  logic         ext_hold_req = 1'b0;
  logic         lbus_gnt = 1'b0;
  logic         gnt_en = 1'b1;
  logic [15:0]  gp_o = '0;
  logic [15:0]  gp_oe = '0;
  logic [15:0]  lo_in = '0;
  logic [7:0]   ssc_o = '0;
  logic [7:0]   ssc_oe = '0;
  logic [3:0]   rdy_dly = '0;
  logic         host_mode, ale, rd_n, wr_n, strobe_oe, local_ready_n;
  logic         lbus_req, ext_hold_ack, lbi_busy, rd_data_held;
  logic [31:0]  host_addr, pin_i, pin_o, pin_oe, pv;
  logic [15:0]  data_drv, gp_i;
  logic [7:0]   ssc_i;
  logic [7:0]   ref_m [int];
  // Only documented pin configuration codes are used
  logic [2:0]   codes [4] = '{PCFG_HOST_STRAP_A_ALL, PCFG_GP_HI, PCFG_SSC_MUX,
                              PCFG_GP_MUX};
  int           seed, mismatches, checks, n;
  always #5 clk = ~clk;
  assign pin_i = (pin_o & pin_oe) | ({data_drv, lo_in} & ~pin_oe);
  always @(negedge clk) lbus_gnt <= lbus_req && gnt_en;
  lbb_bridge #(.LCLK_DIV(2)) dut (
    .clk(clk), .arst_n(arst_n), .pci_req(pci_req), .pci_rsp(pci_rsp),
    .periph_pin_config(periph_pin_config),
    .local_bus_config(local_bus_config), .host_strap_a(host_strap_a),
    .host_mode(host_mode), .host_addr(host_addr),
    .addr_latch_strobe(ale), .local_read_strobe_n(rd_n),
    .local_write_strobe_n(wr_n), .strobe_oe(strobe_oe),
    .local_ready_n(local_ready_n), .lbus_req(lbus_req),
    .lbus_gnt(lbus_gnt), .ext_hold_req(ext_hold_req),
    .ext_hold_ack(ext_hold_ack), .lbi_busy(lbi_busy),
    .rd_data_held(rd_data_held), .gp_io_port_o(gp_o),
    .gp_io_port_oe(gp_oe), .gp_io_port_i(gp_i), .sync_serial_port_o(ssc_o),
    .sync_serial_port_oe(ssc_oe), .sync_serial_port_i(ssc_i), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe(pin_oe));
  lbb_lbus_periph per (
    .clk(clk), .pcfg(periph_pin_config), .width16(local_bus_config.width16),
    .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .pin_o(pin_o),
    .bus_seen(pin_i[31:16]), .rdy_dly(rdy_dly), .data_drv(data_drv),
    .ready_n(local_ready_n));
  ////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk_rsp(input logic [2:0] got, input logic [2:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_dat(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic req(input logic w, input logic b, input logic [15:0] a,
                     input logic [31:0] d);
    @(negedge clk);
    pci_req = '{1'b1, w, b, a, d};
    @(posedge clk);
    rsp = pci_rsp;
    @(negedge clk);
    pci_req.valid = 1'b0;
  endtask
  task automatic wait_for(input int sel);
    n = 0;
    while (n < 3000 && (sel == 0 ? lbi_busy : !rd_data_held)) begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000) mismatches++;
  endtask
  task automatic rt(input logic [15:0] a);
    logic [31:0] d;
    d = $random(seed);
    req(1'b1, 1'b0, a, d);
    chk_rsp({rsp.ack, rsp.retry, rsp.disc}, 3'b100);
    req(1'b1, 1'b1, a, ~d);
    chk_rsp({rsp.ack, rsp.retry, rsp.disc}, 3'b010);
    for (int i = 0; i < 4; i++) ref_m[a + i] = d[8*i +: 8];
    wait_for(0);
    chk_dat(per.rd32(a), d);
    req(1'b0, 1'b0, a, 32'h0);
    chk_rsp({rsp.ack, rsp.retry, rsp.disc}, 3'b010);
    wait_for(1);
    req(1'b0, 1'b1, a, 32'h0);
    chk_rsp({rsp.ack, rsp.retry, rsp.disc}, 3'b101);
    pv = {ref_m[a+3], ref_m[a+2], ref_m[a+1], ref_m[a]};
    chk_dat(rsp.rdata, pv);
  endtask
  initial begin
    #200_000;
    mismatches++;
    end_of_test();
  end
  initial begin
    seed = 32'h79d8;
    repeat (10) @(posedge clk);
    @(negedge clk) arst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk_dat(pin_oe, 32'h0000ffff);
    chk_dat({28'h0, rd_n, wr_n, ale, host_mode}, 32'hc);
    for (int w = 1; w >= 0; w--) begin
      for (int c = 0; c < 4; c++) begin
        @(negedge clk);
        periph_pin_config = codes[c];
        local_bus_config.width16 = w[0];
        local_bus_config.cycle_wait_count = 4'hd + 4'({$random(seed)} % 3);
        local_bus_config.ready_wait_enable = ((c + w) % 2 == 1);
        local_bus_config.rdy_ws = 3'($random(seed));
        rdy_dly = 4'($random(seed));
        {gp_o, gp_oe, lo_in} = 48'({$random(seed), $random(seed)});
        {ssc_o, ssc_oe} = 16'($random(seed));
        repeat (3) @(negedge clk);
        case (c)
          0: pv = 32'hffff;
          1: pv = {gp_oe[15:8], 8'hff};
          2: pv = {gp_oe[15:8], ssc_oe};
          default: pv = gp_oe;
        endcase
        chk_dat({16'h0, pin_oe[15:0]}, pv);
        chk_dat({8'h0, gp_i, ssc_i}, {8'h0, pin_i[15:0], pin_i[7:0]});
        rt(16'($random(seed)) & (c == 1 ? 16'h00fc : 16'hfffc));
        $display("test cfg %0d width16 %0d done", c, w);
      end
    end
    periph_pin_config = PCFG_HOST_STRAP_A_ALL;
    local_bus_config.arb_slave = 1'b1;
    gnt_en = 1'b0;
    repeat (3) @(negedge clk);
    req(1'b1, 1'b0, 16'h0040, 32'h1234abcd);
    chk_rsp({rsp.ack, rsp.retry, rsp.disc}, 3'b100);
    repeat (20) @(negedge clk);
    chk_dat({29'h0, lbus_req, wr_n, strobe_oe}, 32'h6);
    gnt_en = 1'b1;
    wait_for(0);
    chk_dat(per.rd32(16'h0040), 32'h1234abcd);
    local_bus_config.arb_slave = 1'b0;
    $display("test arbitration slave done");
    repeat (3) @(negedge clk);
    ext_hold_req = 1'b1;
    repeat (10) @(negedge clk);
    chk_dat({ext_hold_ack, strobe_oe, pin_oe[31:16]}, 32'h20000);
    ext_hold_req = 1'b0;
    repeat (10) @(negedge clk);
    chk_dat({31'h0, ext_hold_ack}, 32'h0);
    $display("test external hold done");
    periph_pin_config = PCFG_GP_MUX;
    host_strap_a = 1'b1;
    arst_n = 1'b0;
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    pv = pin_i;
    @(negedge clk);
    chk_dat(host_addr, pv);
    chk_dat({pin_oe[31:1], host_mode}, 32'h1);
    $display("test strap mode done");
    end_of_test();
  end
endmodule
